// ===== design/adcsq_top.sv
`timescale 1ns/1ps
`include "adcsq_consts.svh"


module adcsq_top #(parameter int PINS = 8)
(
  input  wire logic            MCLK,           // System clock, 50 MHz
  input  wire logic            NRST,           // Async reset, active low
  input  wire logic [3:0]      AVS_ADDRESS,    // Byte address
  input  wire logic            AVS_READ,       // Read strobe
  input  wire logic            AVS_WRITE,      // Write strobe
  input  wire logic [3:0]      AVS_BYTEENABLE, // Byte lanes
  input  wire logic [31:0]     AVS_WRITEDATA,  // Write data
  output logic      [31:0]     AVS_READDATA,   // Read data
  output logic                 AVS_WAITREQUEST,// Wait request
  input  wire logic [11:0]     CONV_RESULT,    // Result from analog core
  input  wire logic [PINS-1:0] PULL_EN,        // Software pull-high enables
  input  wire logic [PINS-1:0] PORT_DIR,       // Software port directions
  output logic                 CONV_POWER_ON,  // Analog core powered
  output logic                 CONV_RESET,     // Analog core held in reset
  output logic                 CONV_CLK_TICK,  // Conversion clock tick
  output logic [2:0]           CHANNEL_SEL,    // Input channel select
  output logic [PINS-1:0]      ANALOG_SEL,     // Pin used as analog input
  output logic [PINS-1:0]      PULL_ACTIVE,    // Effective pull-high
  output logic [PINS-1:0]      DIR_ACTIVE,     // Effective direction
  output logic                 IRQ_REQ         // Converter interrupt request
);

  if (PINS < 1 || PINS > 8)
    $error("PINS must be 1..8");

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic       test_bit;
  logic       converter_power_off;
  logic [2:0] conversion_clock_divider_select;
  logic       start;
  logic       conversion_busy_flag;
  logic [2:0] analog_pin_config;
  logic [2:0] input_channel_select;
  logic       master_interrupt_enable, converter_interrupt_enable;
  logic       irq_flag;
  logic [11:0] result;
  logic [4:0] tick_cnt;
  logic       done, tick, pwr_on;
  logic [PINS-1:0] analog_w, pull_w, dir_w;
  adcsq_pkg::adcsq_state_t state;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic       wr_acc, wr_cp, wr_ct, wr_ic, start_rise, start_fall;

  // One wait cycle per access so every answer comes from a register
  assign wr_acc = AVS_WRITE && !AVS_WAITREQUEST;
  assign wr_cp  = wr_acc && AVS_BYTEENABLE[0] && AVS_ADDRESS == `ADCSQ_OFS_CLKPWR;
  assign wr_ct  = wr_acc && AVS_BYTEENABLE[0] && AVS_ADDRESS == `ADCSQ_OFS_CTRL;
  // Interrupt control shares word 0 in byte lane 1
  assign wr_ic  = wr_acc && AVS_BYTEENABLE[1] && AVS_ADDRESS == `ADCSQ_OFS_INTCTL;
  assign start_rise = wr_ct && !start && AVS_WRITEDATA[`ADCSQ_CT_START];
  assign start_fall = wr_ct && start && !AVS_WRITEDATA[`ADCSQ_CT_START];

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      AVS_WAITREQUEST <= 1'b1;
    else
      AVS_WAITREQUEST <= !(AVS_WAITREQUEST && (AVS_READ || AVS_WRITE));
  end

  // ---------------------------------------------------------------
  // Clock and power control
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      test_bit                        <= 1'b1;
      converter_power_off             <= 1'b0;
      conversion_clock_divider_select <= 3'b000;
    end
    else if (wr_cp)
    begin
      test_bit                        <= AVS_WRITEDATA[`ADCSQ_CP_TEST];
      converter_power_off             <= AVS_WRITEDATA[`ADCSQ_CP_PWROFF];
      conversion_clock_divider_select <= AVS_WRITEDATA[2:0];
    end
  end

  // ---------------------------------------------------------------
  // Converter control
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      start                <= 1'b0;
      analog_pin_config    <= 3'b000;
      input_channel_select <= 3'b000;
    end
    else if (wr_ct)
    begin
      start                <= AVS_WRITEDATA[`ADCSQ_CT_START];
      analog_pin_config    <= AVS_WRITEDATA[5:3];
      input_channel_select <= AVS_WRITEDATA[2:0];
    end
  end

  assign pwr_on = !converter_power_off && analog_pin_config != 3'b000;

  adcsq_clkdiv u_div
  (
    .clk     (MCLK),
    .rst_n   (NRST),
    .restart (start_fall),
    .sel     (conversion_clock_divider_select),
    .tick    (tick)
  );

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  assign done = state == adcsq_pkg::ADCSQ_CONV && tick && tick_cnt == `ADCSQ_CONV_TICKS - 5'd1;

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      state    <= adcsq_pkg::ADCSQ_IDLE;
      tick_cnt <= 5'd0;
    end
    else if (start_rise || !pwr_on)
    begin
      state    <= start_rise ? adcsq_pkg::ADCSQ_RESET : adcsq_pkg::ADCSQ_IDLE;
      tick_cnt <= 5'd0;
    end
    else
    begin
      unique case (state)
        adcsq_pkg::ADCSQ_IDLE:
          tick_cnt <= 5'd0;
        adcsq_pkg::ADCSQ_RESET:
          if (start_fall)
          begin
            state    <= adcsq_pkg::ADCSQ_CONV;
            tick_cnt <= 5'd0;
          end
        adcsq_pkg::ADCSQ_CONV:
          if (done)
            state <= adcsq_pkg::ADCSQ_IDLE;
          else if (tick)
            tick_cnt <= tick_cnt + 5'd1;
        default:
          state <= adcsq_pkg::ADCSQ_IDLE;
      endcase
    end
  end

  // Busy resets to 1 until a conversion has finished
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      conversion_busy_flag <= 1'b1;
    else if (start_rise)
      conversion_busy_flag <= 1'b1;
    else if (done)
      conversion_busy_flag <= 1'b0;
  end

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      result <= 12'h000;
    else if (done)
      result <= CONV_RESULT;
  end

  // ---------------------------------------------------------------
  // Interrupt request
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      master_interrupt_enable    <= 1'b0;
      converter_interrupt_enable <= 1'b0;
    end
    else if (wr_ic)
    begin
      master_interrupt_enable    <= AVS_WRITEDATA[8 + `ADCSQ_IC_MASTER];
      converter_interrupt_enable <= AVS_WRITEDATA[8 + `ADCSQ_IC_CONV];
    end
  end

  // Set wins over a simultaneous software clear
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      irq_flag <= 1'b0;
    else if (done)
      irq_flag <= 1'b1;
    else if (wr_ic && !AVS_WRITEDATA[8 + `ADCSQ_IC_FLAG])
      irq_flag <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Pins and outputs
  // ---------------------------------------------------------------
  adcsq_pinmux #(.PINS(PINS)) u_pins
  (
    .cfg      (analog_pin_config),
    .pull_en  (PULL_EN),
    .dir_in   (PORT_DIR),
    .analog   (analog_w),
    .pull_out (pull_w),
    .dir_out  (dir_w)
  );

  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
    begin
      CONV_POWER_ON <= 1'b0;
      CONV_RESET    <= 1'b1;
      CONV_CLK_TICK <= 1'b0;
      CHANNEL_SEL   <= 3'b000;
      ANALOG_SEL    <= '0;
      PULL_ACTIVE   <= '0;
      DIR_ACTIVE    <= '0;
      IRQ_REQ       <= 1'b0;
    end
    else
    begin
      CONV_POWER_ON <= pwr_on;
      CONV_RESET    <= state != adcsq_pkg::ADCSQ_CONV;
      CONV_CLK_TICK <= tick;
      CHANNEL_SEL   <= input_channel_select;
      ANALOG_SEL    <= analog_w;
      PULL_ACTIVE   <= pull_w;
      DIR_ACTIVE    <= dir_w;
      IRQ_REQ       <= irq_flag && master_interrupt_enable && converter_interrupt_enable;
    end
  end

  // ---------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK or negedge NRST)
  begin
    if (!NRST)
      AVS_READDATA <= 32'h0000_0000;
    else if (AVS_READ && AVS_WAITREQUEST)
    begin
      unique case (AVS_ADDRESS)
        `ADCSQ_OFS_CLKPWR: AVS_READDATA <= {21'h0, irq_flag, converter_interrupt_enable,
          master_interrupt_enable, test_bit, converter_power_off, 3'b000,
          conversion_clock_divider_select};
        `ADCSQ_OFS_CTRL:   AVS_READDATA <= {24'h0, start, conversion_busy_flag,
          analog_pin_config, input_channel_select};
        `ADCSQ_OFS_RES_LO: AVS_READDATA <= {24'h0, result[3:0], 4'h0};
        `ADCSQ_OFS_RES_HI: AVS_READDATA <= {24'h0, result[11:4]};
        default:           AVS_READDATA <= 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_busy_done;
    @(posedge MCLK) disable iff (!NRST) done |=> !conversion_busy_flag;
  endproperty
  a_busy_done: assert property (p_busy_done) else $error("Busy not cleared");

  property p_irq_done;
    @(posedge MCLK) disable iff (!NRST) done |=> irq_flag;
  endproperty
  a_irq_done: assert property (p_irq_done) else $error("Flag not set");

  property p_reset_busy;
    @(posedge MCLK) disable iff (!NRST) state == adcsq_pkg::ADCSQ_RESET |-> conversion_busy_flag ##1 CONV_RESET;
  endproperty
  a_reset_busy: assert property (p_reset_busy) else $error("Reset hold broken");

  property p_pwr;
    @(posedge MCLK) disable iff (!NRST) converter_power_off |=> !CONV_POWER_ON;
  endproperty
  a_pwr: assert property (p_pwr) else $error("Power not off");

  property p_cfg0;
    @(posedge MCLK) disable iff (!NRST) analog_pin_config == 3'b000 |=> !CONV_POWER_ON && ANALOG_SEL == '0;
  endproperty
  a_cfg0: assert property (p_cfg0) else $error("Config zero not off");

  property p_pull;
    @(posedge MCLK) disable iff (!NRST) ##1 (ANALOG_SEL & PULL_ACTIVE) == '0;
  endproperty
  a_pull: assert property (p_pull) else $error("Pull on analog pin");

  property p_start;
    @(posedge MCLK) disable iff (!NRST) state == adcsq_pkg::ADCSQ_RESET && start_fall && pwr_on
      |=> state == adcsq_pkg::ADCSQ_CONV && tick_cnt == 5'd0;
  endproperty
  a_start: assert property (p_start) else $error("Start not taken");

  property p_count;
    @(posedge MCLK) disable iff (!NRST) done |-> tick_cnt == 5'd15 && tick;
  endproperty
  a_count: assert property (p_count) else $error("Wrong length");

endmodule

// ===== pkg/adcsq_consts.svh
`ifndef ADCSQ_CONSTS_SVH
`define ADCSQ_CONSTS_SVH

// -----------------------------------------------------------------
// Register byte offsets
// -----------------------------------------------------------------
`define ADCSQ_OFS_CLKPWR   4'h0
`define ADCSQ_OFS_CTRL     4'h4
`define ADCSQ_OFS_RES_LO   4'h8
`define ADCSQ_OFS_RES_HI   4'hC
`define ADCSQ_OFS_INTCTL   4'h0

// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define ADCSQ_CP_TEST      7
`define ADCSQ_CP_PWROFF    6
`define ADCSQ_CT_START     7
`define ADCSQ_CT_BUSY      6
`define ADCSQ_IC_MASTER    0
`define ADCSQ_IC_CONV      1
`define ADCSQ_IC_FLAG      2

// -----------------------------------------------------------------
// Reset values and masks
// -----------------------------------------------------------------
`define ADCSQ_CLKPWR_RST   8'h80
`define ADCSQ_CLKPWR_MASK  8'hC7
`define ADCSQ_CTRL_RST     8'h40

// -----------------------------------------------------------------
// Timing
// -----------------------------------------------------------------
`define ADCSQ_CONV_TICKS   5'd16

`endif

// ===== pkg/adcsq_pkg.sv
package adcsq_pkg;

  typedef enum logic [1:0]
  {
    ADCSQ_IDLE  = 2'b00,
    ADCSQ_RESET = 2'b01,
    ADCSQ_CONV  = 2'b10
  } adcsq_state_t;

  typedef enum logic [2:0]
  {
    ADCSQ_DIV2  = 3'b000,
    ADCSQ_DIV8  = 3'b001,
    ADCSQ_DIV32 = 3'b010,
    ADCSQ_BAD3  = 3'b011,
    ADCSQ_DIV1  = 3'b100,
    ADCSQ_DIV4  = 3'b101,
    ADCSQ_DIV16 = 3'b110,
    ADCSQ_BAD7  = 3'b111
  } adcsq_div_t;

endpackage

// ===== design/adcsq_clkdiv.sv
`timescale 1ns/1ps
`include "adcsq_consts.svh"

module adcsq_clkdiv
(
  input  wire logic       clk,     // System clock
  input  wire logic       rst_n,   // Async reset
  input  wire logic       restart, // Realign prescaler
  input  wire logic [2:0] sel,     // Divider select
  output logic            tick     // One conversion clock period
);

  logic [4:0] cnt;
  logic [4:0] last;

  // mapping; unusable codes fall back to /2
  always_comb
  begin
    unique case (adcsq_pkg::adcsq_div_t'(sel))
      adcsq_pkg::ADCSQ_DIV1:  last = 5'h00;
      adcsq_pkg::ADCSQ_DIV2:  last = 5'h01;
      adcsq_pkg::ADCSQ_DIV4:  last = 5'h03;
      adcsq_pkg::ADCSQ_DIV8:  last = 5'h07;
      adcsq_pkg::ADCSQ_DIV16: last = 5'h0F;
      adcsq_pkg::ADCSQ_DIV32: last = 5'h1F;
      default:                last = 5'h01;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt <= 5'h00;
    else if (restart || cnt >= last)
      cnt <= 5'h00;
    else
      cnt <= cnt + 5'h01;
  end

  assign tick = !restart && (cnt >= last);

endmodule

// ===== design/adcsq_pinmux.sv
`timescale 1ns/1ps

module adcsq_pinmux #(parameter int PINS = 8)
(
  input  wire logic [2:0]      cfg,      // Analog pin configuration
  input  wire logic [PINS-1:0] pull_en,  // Software pull-high enables
  input  wire logic [PINS-1:0] dir_in,   // Software port directions
  output logic      [PINS-1:0] analog,   // Pin used as analog input
  output logic      [PINS-1:0] pull_out, // Effective pull-high
  output logic      [PINS-1:0] dir_out   // Effective direction, 1 = input
);

  // Config n enables the first n pins as analog inputs
  for (genvar i = 0; i < PINS; i++)
  begin : g_pin
    assign analog[i]   = (int'(cfg) > i);
    assign pull_out[i] = pull_en[i] && !analog[i];
    assign dir_out[i]  = analog[i] ? 1'b1 : dir_in[i];
  end

endmodule

// ===== bench/adcsq_core_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Analog core stand-in: result only after 14 conversion ticks
// ------------------------------------------------------------
module adcsq_core_model #(parameter logic [11:0] BASE = 12'hA5C)
(
  input  wire logic        clk,        // System clock
  input  wire logic        power_on,   // Core powered
  input  wire logic        conv_reset, // Core held in reset
  input  wire logic        clk_tick,   // Conversion clock tick
  input  wire logic [2:0]  channel,    // Selected channel
  output logic      [11:0] result      // Conversion result
);
  logic [4:0]  ticks = 5'h00;
  logic [11:0] noise = 12'h3C6;

  always @(posedge clk)
  begin
    noise <= {noise[10:0], noise[11] ^ noise[5]};
    if (!power_on || conv_reset)
      ticks <= 5'h00;
    else if (clk_tick && ticks != 5'h10)
      ticks <= ticks + 5'h01;
  end

  // Unfinished or unpowered core shows a moving pattern, never a stale value
  // Ticks reach the core one register late, so two may still be in flight at capture
  assign result = (ticks >= 5'h0E) ? (BASE ^ {9'h000, channel}) : noise;
endmodule

// ===== bench/tb_adc_sequencing_control.sv
`timescale 1ns/1ps
`include "adcsq_consts.svh"

module tb_adc_sequencing_control;
  logic        MCLK = 1'b0;
  logic        NRST = 1'b0;
  logic [3:0]  AVS_ADDRESS = 4'h0;
  logic        AVS_READ = 1'b0;
  logic        AVS_WRITE = 1'b0;
  logic [3:0]  AVS_BYTEENABLE = 4'h0;
  logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST;
  logic [11:0] CONV_RESULT;
  logic [7:0]  PULL_EN = 8'h5A;
  logic [7:0]  PORT_DIR = 8'h33;
  logic        CONV_POWER_ON;
  logic        CONV_RESET;
  logic        CONV_CLK_TICK;
  logic [2:0]  CHANNEL_SEL;
  logic [7:0]  ANALOG_SEL;
  logic [7:0]  PULL_ACTIVE;
  logic [7:0]  DIR_ACTIVE;
  logic        IRQ_REQ;
  int          n_fail = 0;
  int          tests_run = 0;
  int          run_len = 0;
  int          run_ticks = 0;
  int          last_len = 0;
  int          last_ticks = 0;
  localparam logic [11:0] RES_BASE = 12'hA5C;

  always #10 MCLK = ~MCLK;

  adcsq_top #(.PINS(8)) dut_u
  (
    .MCLK           (MCLK),
    .NRST           (NRST),
    .AVS_ADDRESS    (AVS_ADDRESS),
    .AVS_READ       (AVS_READ),
    .AVS_WRITE      (AVS_WRITE),
    .AVS_BYTEENABLE (AVS_BYTEENABLE),
    .AVS_WRITEDATA  (AVS_WRITEDATA),
    .AVS_READDATA   (AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .CONV_RESULT    (CONV_RESULT),
    .PULL_EN        (PULL_EN),
    .PORT_DIR       (PORT_DIR),
    .CONV_POWER_ON  (CONV_POWER_ON),
    .CONV_RESET     (CONV_RESET),
    .CONV_CLK_TICK  (CONV_CLK_TICK),
    .CHANNEL_SEL    (CHANNEL_SEL),
    .ANALOG_SEL     (ANALOG_SEL),
    .PULL_ACTIVE    (PULL_ACTIVE),
    .DIR_ACTIVE     (DIR_ACTIVE),
    .IRQ_REQ        (IRQ_REQ)
  );

  adcsq_core_model #(.BASE(RES_BASE)) core_u
  (
    .clk       (MCLK),
    .power_on  (CONV_POWER_ON),
    .conv_reset(CONV_RESET),
    .clk_tick  (CONV_CLK_TICK),
    .channel   (CHANNEL_SEL),
    .result    (CONV_RESULT)
  );

  // ------------------------------------------------------------
  // Conversion length monitor, latched when the core re-enters reset
  // ------------------------------------------------------------
  always @(posedge MCLK)
  begin
    if (CONV_RESET === 1'b0)
    begin
      run_len <= run_len + 1;
      if (CONV_CLK_TICK === 1'b1)
        run_ticks <= run_ticks + 1;
    end
    else if (run_len != 0)
    begin
      last_len <= run_len;
      last_ticks <= run_ticks;
      run_len <= 0;
      run_ticks <= 0;
    end
  end

  // ------------------------------------------------------------
  // Checking and verdict
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Bus master: one idle edge after release keeps strobes single-driven
  // ------------------------------------------------------------
  task automatic acc(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_BYTEENABLE <= be;
    AVS_READ <= ~wr;
    AVS_WRITE <= wr;
    do
      @(posedge MCLK);
    while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    @(posedge MCLK);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    acc(1'b1, a, d, be, q);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    acc(1'b0, a, 32'h0000_0000, 4'hF, q);
  endtask

  // ------------------------------------------------------------
  // One conversion, optionally restarted midway
  // ------------------------------------------------------------
  task automatic conv(input logic [2:0] code, input int div, input logic [2:0] ch,
                      input logic en, input logic restart);
    logic [31:0] q;
    logic [11:0] r;
    int          n;
    r = RES_BASE ^ {9'h000, ch};
    wr(`ADCSQ_OFS_CLKPWR, {24'h00_0000, 2'b01, 3'b000, code}, 4'b0001);
    wr(`ADCSQ_OFS_CTRL, {24'h00_0000, 2'b00, 3'b111, 3'b000}, 4'b0001);
    wr(`ADCSQ_OFS_CLKPWR, {29'h0000_0000, code}, 4'b0001);
    wr(`ADCSQ_OFS_CTRL, {24'h00_0000, 2'b00, 3'b111, ch}, 4'b0001);
    wr(`ADCSQ_OFS_CLKPWR, {22'h00_0000, en, en, 8'h00}, 4'b0010);
    rd(`ADCSQ_OFS_CLKPWR, q);
    check({31'h0000_0000, q[10]}, 32'h0000_0000);
    wr(`ADCSQ_OFS_CTRL, {24'h00_0000, 2'b10, 3'b111, ch}, 4'b0001);
    rd(`ADCSQ_OFS_CTRL, q);
    check(q & 32'h0000_00C0, 32'h0000_00C0);
    check({31'h0000_0000, CONV_RESET}, 32'h0000_0001);
    wr(`ADCSQ_OFS_CTRL, {24'h00_0000, 2'b00, 3'b111, ch}, 4'b0001);
    if (restart)
    begin
      repeat (60) @(posedge MCLK);
      wr(`ADCSQ_OFS_CTRL, {24'h00_0000, 2'b10, 3'b111, ch}, 4'b0001);
      @(posedge MCLK);
      check({31'h0000_0000, CONV_RESET}, 32'h0000_0001);
      wr(`ADCSQ_OFS_CTRL, {24'h00_0000, 2'b00, 3'b111, ch}, 4'b0001);
    end
    n = 0;
    q = 32'h0000_0040;
    while (q[6] !== 1'b0 && n < 400)
    begin
      rd(`ADCSQ_OFS_CTRL, q);
      n++;
    end
    check({31'h0000_0000, q[6]}, 32'h0000_0000);
    repeat (2) @(posedge MCLK);
    check(32'(last_ticks), 32'h0000_0010);
    check({31'h0000_0000, last_len >= 16 * div - 1 && last_len <= 16 * div + 2}, 32'h0000_0001);
    check({31'h0000_0000, IRQ_REQ}, {31'h0000_0000, en});
    rd(`ADCSQ_OFS_CLKPWR, q);
    check({31'h0000_0000, q[10]}, 32'h0000_0001);
    rd(`ADCSQ_OFS_RES_HI, q);
    check(q, {24'h00_0000, r[11:4]});
    rd(`ADCSQ_OFS_RES_LO, q);
    check(q, {24'h00_0000, r[3:0], 4'h0});
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  adcsq_pkg::adcsq_div_t codes[6] = '{adcsq_pkg::ADCSQ_DIV2, adcsq_pkg::ADCSQ_DIV8, adcsq_pkg::ADCSQ_DIV32,
                                      adcsq_pkg::ADCSQ_DIV1, adcsq_pkg::ADCSQ_DIV4, adcsq_pkg::ADCSQ_DIV16};
  int divs[6] = '{2, 8, 32, 1, 4, 16};

  initial
  begin
    logic [31:0] q;
    logic [7:0]  an;
    repeat (3) @(posedge MCLK);
    NRST <= 1'b1;
    rd(`ADCSQ_OFS_CLKPWR, q);
    check(q, 32'h0000_0080);
    rd(`ADCSQ_OFS_CTRL, q);
    check(q, 32'h0000_0040);
    wr(`ADCSQ_OFS_CLKPWR, 32'h0000_00FE, 4'b0001);
    rd(`ADCSQ_OFS_CLKPWR, q);
    check(q, 32'h0000_00C6);
    wr(`ADCSQ_OFS_CLKPWR, 32'h0000_0000, 4'b0001);
    for (int c = 0; c < 8; c++)
    begin
      an = 8'((16'h0001 << c) - 16'h0001);
      wr(`ADCSQ_OFS_CTRL, 32'(c) << 3, 4'b0001);
      repeat (2) @(posedge MCLK);
      check({24'h00_0000, ANALOG_SEL}, {24'h00_0000, an});
      check({24'h00_0000, PULL_ACTIVE}, {24'h00_0000, PULL_EN & ~an});
      check({24'h00_0000, DIR_ACTIVE}, {24'h00_0000, PORT_DIR | an});
      check({31'h0000_0000, CONV_POWER_ON}, {31'h0000_0000, c != 0});
    end
    wr(`ADCSQ_OFS_CLKPWR, 32'h0000_0040, 4'b0001);
    repeat (2) @(posedge MCLK);
    check({31'h0000_0000, CONV_POWER_ON}, 32'h0000_0000);
    for (int i = 0; i < 6; i++)
      conv(codes[i], divs[i], 3'(i), i[0], 1'b0);
    conv(adcsq_pkg::ADCSQ_DIV32, 32, 3'h7, 1'b1, 1'b1);
    wr(`ADCSQ_OFS_CLKPWR, 32'h0000_0042, 4'b0001);
    repeat (2) @(posedge MCLK);
    check({31'h0000_0000, CONV_POWER_ON}, 32'h0000_0000);
    print_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge MCLK);
    n_fail++;
    print_verdict();
  end
endmodule
